// file: dram_init_seq.sv
// host-side power-up and warm-reset initialization sequencer for a ddr4 memory
`timescale 1ns/1ps
`include "dram_init_regs.svh"
module dram_init_seq #(
    parameter int CLK_DIV = 8,
    parameter int unsigned RESET_HOLD_CYC =
        (`INIT_RESET_HOLD_US * 1000 + `INIT_ACLK_PERIOD_NS - 1) / `INIT_ACLK_PERIOD_NS,
    parameter int unsigned TEN_HOLD_CYC =
        (`INIT_TEN_HOLD_US * 1000 + `INIT_ACLK_PERIOD_NS - 1) / `INIT_ACLK_PERIOD_NS,
    parameter int unsigned CKE_WAIT_CYC =
        (`INIT_CKE_WAIT_US * 1000 + `INIT_ACLK_PERIOD_NS - 1) / `INIT_ACLK_PERIOD_NS,
    parameter int unsigned RESET_PULSE_NS = 1000,
    parameter int unsigned SELF_REFRESH_EXIT_NS = 500,
    parameter int unsigned DLL_LOCK_CLKS = 1024,
    parameter int unsigned ZQ_INIT_CLKS = 1024,
    parameter int unsigned CMD_GAP_CLKS = 24
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic mem_reset_n,
    output logic clock_enable,
    output logic connectivity_test_enable,
    output logic termination_control_in,
    output logic diff_clock_true,
    output logic diff_clock_comp,
    output logic cs_n,
    output logic act_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic bank_group_bit,
    output logic bank_addr_bit1,
    output logic bank_addr_bit0,
    output logic [13:0] addr
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic int unsigned ns_to_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + `INIT_ACLK_PERIOD_NS - 1) / `INIT_ACLK_PERIOD_NS;
        return (c == 0) ? 1 : c;
    endfunction : ns_to_cyc

    function automatic int unsigned max2(input int unsigned a, input int unsigned b);
        return (a > b) ? a : b;
    endfunction : max2

    function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[i*8 +: 8] = data[i*8 +: 8];
        return res;
    endfunction : apply_strb

    function automatic logic [2:0] mr_select(input logic [2:0] step);
        case (step)
            3'h0: return 3'h3;
            3'h1: return 3'h6;
            3'h2: return 3'h5;
            3'h3: return 3'h4;
            3'h4: return 3'h2;
            3'h5: return 3'h1;
            default: return 3'h0;
        endcase
    endfunction : mr_select

    // fields that must hold zero codes whatever software wrote
    function automatic logic [13:0] mr_op(input logic [2:0] sel, input logic [13:0] v);
        logic [13:0] o;
        o = v;
        case (sel)
            3'h3: o[4:3] = 2'h0;
            3'h4:
            begin
                o[8:6] = 3'h0;
                o[13] = 1'b0;
                o[5] = 1'b0;
            end
            3'h5: o[2:0] = 3'h0;
            default: o = v;
        endcase
        return o;
    endfunction : mr_op

    localparam int unsigned CKE_SETUP_CYC = ns_to_cyc(`INIT_CKE_SETUP_NS);
    localparam int unsigned PU_HOLD_CYC = max2(RESET_HOLD_CYC, CKE_SETUP_CYC);
    localparam int unsigned WARM_HOLD_CYC = max2(ns_to_cyc(RESET_PULSE_NS), CKE_SETUP_CYC);
    localparam int unsigned CLK_STABLE_CYC =
        max2(ns_to_cyc(`INIT_CLK_STABLE_NS), `INIT_CLK_STABLE_CLKS * CLK_DIV);
    localparam int unsigned XPR_CYC =
        max2(ns_to_cyc(SELF_REFRESH_EXIT_NS), `INIT_XPR_CLKS * CLK_DIV) + CLK_DIV;
    localparam int unsigned CMD_GAP_CYC = CMD_GAP_CLKS * CLK_DIV;
    localparam int unsigned CAL_CYC = max2(DLL_LOCK_CLKS, ZQ_INIT_CLKS) * CLK_DIV;

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic aw_pend_r, w_pend_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r, rdata_r;
    logic [3:0] w_strb_r;
    dram_init_pkg::axi_resp_t bresp_r, rresp_r;
    logic do_write;
    logic [31:0] ctrl_r;
    logic start_req_r;
    logic [13:0] mr_val_r [7];
    dram_init_pkg::seq_state_t state_r;
    logic ten_ok_r;

    assign do_write = aw_pend_r && w_pend_r && !bvalid_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_r <= 1'b0;
            aw_pend_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end
        else if (awvalid && awready_r)
        begin
            awready_r <= 1'b0;
            aw_pend_r <= 1'b1;
            aw_addr_r <= awaddr;
        end
        else if (do_write)
            aw_pend_r <= 1'b0;
        else if (!aw_pend_r && !bvalid_r)
            awready_r <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wready_r <= 1'b0;
            w_pend_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else if (wvalid && wready_r)
        begin
            wready_r <= 1'b0;
            w_pend_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
        end
        else if (do_write)
            w_pend_r <= 1'b0;
        else if (!w_pend_r && !bvalid_r)
            wready_r <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= dram_init_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= (aw_addr_r == `INIT_CTRL_OFS || aw_addr_r == `INIT_STATUS_OFS ||
                        (aw_addr_r >= `INIT_MR_BASE_OFS && aw_addr_r <= `INIT_MR_LAST_OFS &&
                         aw_addr_r[1:0] == 2'h0)) ? dram_init_pkg::RESP_OKAY
                                                   : dram_init_pkg::RESP_SLVERR;
        end
        else if (bvalid_r && bready)
            bvalid_r <= 1'b0;
    end

    // start is write-one, one cycle wide; status writes are accepted and dropped
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= `INIT_CTRL_RESET;
            start_req_r <= 1'b0;
            for (int i = 0; i < 7; i++)
                mr_val_r[i] <= `INIT_MR_RESET;
        end
        else
        begin
            start_req_r <= 1'b0;
            if (do_write && aw_addr_r == `INIT_CTRL_OFS)
            begin
                ctrl_r <= apply_strb(ctrl_r, w_data_r, w_strb_r) & 32'h0000_000e;
                start_req_r <= w_strb_r[0] && w_data_r[`INIT_CTRL_START_BIT];
            end
            for (int i = 0; i < 7; i++)
                if (do_write && aw_addr_r == `INIT_MR_BASE_OFS + 8'(i * 4))
                    mr_val_r[i] <= 14'(apply_strb({18'h0, mr_val_r[i]}, w_data_r, w_strb_r));
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= dram_init_pkg::RESP_OKAY;
        end
        else if (arvalid && arready_r)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= dram_init_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            if (araddr == `INIT_CTRL_OFS)
                rdata_r <= ctrl_r;
            else if (araddr == `INIT_STATUS_OFS)
            begin
                rdata_r[`INIT_STAT_BUSY_BIT] <= state_r != dram_init_pkg::ST_IDLE &&
                                                state_r != dram_init_pkg::ST_DONE;
                rdata_r[`INIT_STAT_DONE_BIT] <= state_r == dram_init_pkg::ST_DONE;
                rdata_r[`INIT_STAT_TENOK_BIT] <= ten_ok_r;
                rdata_r[`INIT_STAT_STATE_LSB +: 4] <= 4'(state_r);
            end
            else if (araddr >= `INIT_MR_BASE_OFS && araddr <= `INIT_MR_LAST_OFS &&
                     araddr[1:0] == 2'h0)
                rdata_r <= {18'h0, mr_val_r[3'(araddr[4:2] - 3'h4)]};
            else
                rresp_r <= dram_init_pkg::RESP_SLVERR;
        end
        else if (rvalid_r && rready)
            rvalid_r <= 1'b0;
        else if (!rvalid_r)
            arready_r <= 1'b1;
    end

    // ----------------------------------------------------------------
    // clock, timers
    // ----------------------------------------------------------------
    logic clk_run_r, launch;
    logic step_load_r, step_done;
    logic [31:0] step_val_r;
    logic ten_load_r, ten_done, ten_armed_r;

    diff_clock_gen #(.DIV(CLK_DIV)) u_clk (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(clk_run_r),
        .clk_true(diff_clock_true),
        .clk_comp(diff_clock_comp),
        .launch(launch)
    );

    wait_timer #(.W(32)) u_step (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(step_load_r),
        .value(step_val_r),
        .done(step_done)
    );

    wait_timer #(.W(32)) u_ten (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(ten_load_r),
        .value(32'(TEN_HOLD_CYC)),
        .done(ten_done)
    );

    // test enable only after the power-up hold has run out
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ten_load_r <= 1'b0;
            ten_armed_r <= 1'b0;
            ten_ok_r <= 1'b0;
        end
        else
        begin
            ten_load_r <= start_req_r && ctrl_r[`INIT_CTRL_POWERUP_BIT];
            if (start_req_r && ctrl_r[`INIT_CTRL_POWERUP_BIT])
                ten_armed_r <= 1'b1;
            ten_ok_r <= ten_armed_r && ten_done && !ten_load_r &&
                        !(start_req_r && ctrl_r[`INIT_CTRL_POWERUP_BIT]);
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    logic [2:0] mr_step_r;
    logic step_ok;
    logic [2:0] sel;
    logic cke_r, rst_n_r, term_r, ten_r;
    logic cs_n_r, act_n_r, ras_n_r, cas_n_r, we_n_r, bg_r, ba1_r, ba0_r;
    logic [13:0] addr_r;

    assign step_ok = step_done && !step_load_r;
    assign sel = mr_select(mr_step_r);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= dram_init_pkg::ST_IDLE;
            rst_n_r <= 1'b0;
            cke_r <= 1'b0;
            clk_run_r <= 1'b0;
            term_r <= 1'b0;
            mr_step_r <= 3'h0;
            step_load_r <= 1'b0;
            step_val_r <= 32'h0000_0000;
            cs_n_r <= 1'b1;
            act_n_r <= 1'b1;
            ras_n_r <= 1'b1;
            cas_n_r <= 1'b1;
            we_n_r <= 1'b1;
            bg_r <= 1'b0;
            ba1_r <= 1'b0;
            ba0_r <= 1'b0;
            addr_r <= 14'h0000;
        end
        else
        begin
            step_load_r <= 1'b0;
            if (launch)
                cs_n_r <= 1'b1;
            if (start_req_r)
            begin
                // restart from any state; the clock enable drops with the reset
                state_r <= dram_init_pkg::ST_RST_HOLD;
                rst_n_r <= 1'b0;
                cke_r <= 1'b0;
                clk_run_r <= 1'b0;
                cs_n_r <= 1'b1;
                mr_step_r <= 3'h0;
                step_load_r <= 1'b1;
                step_val_r <= ctrl_r[`INIT_CTRL_POWERUP_BIT] ? 32'(PU_HOLD_CYC)
                                                             : 32'(WARM_HOLD_CYC);
                term_r <= ctrl_r[`INIT_CTRL_TERM_BIT] &&
                          mr_val_r[1][`INIT_TERM_NOM_MSB:`INIT_TERM_NOM_LSB] == 3'h0;
            end
            else
            begin
                case (state_r)
                    dram_init_pkg::ST_RST_HOLD:
                        if (step_ok)
                        begin
                            rst_n_r <= 1'b1;
                            step_load_r <= 1'b1;
                            step_val_r <= 32'(CKE_WAIT_CYC);
                            state_r <= dram_init_pkg::ST_WAIT_CKE;
                        end
                    dram_init_pkg::ST_WAIT_CKE:
                        if (step_ok)
                        begin
                            clk_run_r <= 1'b1;
                            step_load_r <= 1'b1;
                            step_val_r <= 32'(CLK_STABLE_CYC);
                            state_r <= dram_init_pkg::ST_CLK_STABLE;
                        end
                    dram_init_pkg::ST_CLK_STABLE:
                        if (step_ok && launch)
                        begin
                            cke_r <= 1'b1;
                            step_load_r <= 1'b1;
                            step_val_r <= 32'(XPR_CYC);
                            state_r <= dram_init_pkg::ST_WAIT_XPR;
                        end
                    dram_init_pkg::ST_WAIT_XPR, dram_init_pkg::ST_CMD_GAP:
                        if (step_ok && launch)
                        begin
                            cs_n_r <= 1'b0;
                            act_n_r <= 1'b1;
                            ras_n_r <= (state_r == dram_init_pkg::ST_CMD_GAP &&
                                        mr_step_r == 3'h7);
                            cas_n_r <= (state_r == dram_init_pkg::ST_CMD_GAP &&
                                        mr_step_r == 3'h7);
                            we_n_r <= 1'b0;
                            step_load_r <= 1'b1;
                            if (state_r == dram_init_pkg::ST_CMD_GAP && mr_step_r == 3'h7)
                            begin
                                addr_r <= 14'h0400;
                                step_val_r <= 32'(CAL_CYC);
                                state_r <= dram_init_pkg::ST_WAIT_CAL;
                            end
                            else
                            begin
                                {bg_r, ba1_r, ba0_r} <= sel;
                                addr_r <= mr_op(sel, mr_val_r[sel]);
                                mr_step_r <= mr_step_r + 3'h1;
                                step_val_r <= 32'(CMD_GAP_CYC);
                                state_r <= dram_init_pkg::ST_CMD_GAP;
                            end
                        end
                    dram_init_pkg::ST_WAIT_CAL:
                        if (step_ok)
                            state_r <= dram_init_pkg::ST_DONE;
                    dram_init_pkg::ST_IDLE, dram_init_pkg::ST_DONE:
                        state_r <= state_r;
                    default:
                        state_r <= dram_init_pkg::ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ten_r <= 1'b0;
        else
            ten_r <= ctrl_r[`INIT_CTRL_TEN_BIT] && ten_ok_r;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign mem_reset_n = rst_n_r;
    assign clock_enable = cke_r;
    assign connectivity_test_enable = ten_r;
    assign termination_control_in = term_r;
    assign cs_n = cs_n_r;
    assign act_n = act_n_r;
    assign ras_n = ras_n_r;
    assign cas_n = cas_n_r;
    assign we_n = we_n_r;
    assign bank_group_bit = bg_r;
    assign bank_addr_bit1 = ba1_r;
    assign bank_addr_bit0 = ba0_r;
    assign addr = addr_r;
endmodule : dram_init_seq

// file: dram_init_regs.svh
// register map, field positions, reset values and timings of the dram init sequencer
`ifndef DRAM_INIT_REGS_SVH
`define DRAM_INIT_REGS_SVH
// How it works
// - before use, gear-down, per-device, latency and repair fields are forced to zero codes
// - on power-up hold the memory reset low at least 200 us
// - on power-up keep connectivity test enable low at least 700 us
// - clock enable is low at least 10 ns before reset is released
// - after reset release wait 500 us before raising clock enable
// - clock runs max(10 ns, 5 periods) before clock enable; deselect on that edge
// - once raised, clock enable stays high until initialization ends
// - termination control is static from clock enable on; low if nominal termination used
// - after clock enable wait max(self-refresh exit, 5 clocks) before first mode load
// - mode registers load in order 3, 6, 5, 4, 2, 1, 0
// - selected mode register is {bank group, bank addr 1, bank addr 0}
// - after mode register 0 issue a long impedance calibration
// - ready only after both dll lock and initial calibration times elapse
// - every idle slot from clock enable to the end carries a deselect
// - every mode register is loaded during initialization
// - warm reset holds reset for the pulse width, clock enable low 10 ns before release
// - after a warm reset repeat the steps from the 500 us wait onward
// - the memory reset is only an asynchronous reset and stays high otherwise

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define INIT_CTRL_OFS 8'h00
`define INIT_STATUS_OFS 8'h04
`define INIT_MR_BASE_OFS 8'h10
`define INIT_MR_LAST_OFS 8'h28

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define INIT_CTRL_START_BIT 0
`define INIT_CTRL_POWERUP_BIT 1
`define INIT_CTRL_TERM_BIT 2
`define INIT_CTRL_TEN_BIT 3
`define INIT_CTRL_RESET 32'h0000_0002
`define INIT_STAT_BUSY_BIT 0
`define INIT_STAT_DONE_BIT 1
`define INIT_STAT_TENOK_BIT 2
`define INIT_STAT_STATE_LSB 8
`define INIT_MR_RESET 14'h0000
`define INIT_TERM_NOM_MSB 10
`define INIT_TERM_NOM_LSB 8

// ----------------------------------------------------------------
// timings in their own units
// ----------------------------------------------------------------
`define INIT_ACLK_PERIOD_NS 10
`define INIT_RESET_HOLD_US 200
`define INIT_TEN_HOLD_US 700
`define INIT_CKE_WAIT_US 500
`define INIT_CKE_SETUP_NS 10
`define INIT_CLK_STABLE_NS 10
`define INIT_CLK_STABLE_CLKS 5
`define INIT_XPR_CLKS 5
`endif

// file: dram_init_pkg.sv
// types shared by the dram init sequencer
package dram_init_pkg;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RST_HOLD,
        ST_WAIT_CKE,
        ST_CLK_STABLE,
        ST_WAIT_XPR,
        ST_CMD_GAP,
        ST_WAIT_CAL,
        ST_DONE
    } seq_state_t;
    typedef logic [1:0] axi_resp_t;
    localparam axi_resp_t RESP_OKAY = 2'h0;
    localparam axi_resp_t RESP_SLVERR = 2'h2;
endpackage : dram_init_pkg

// file: wait_timer.sv
// down-counting wait timer with a registered done flag
`timescale 1ns/1ps
module wait_timer #(
    parameter int W = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);
    logic [W-1:0] count_r;
    logic done_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_r <= '0;
            done_r <= 1'b1;
        end
        else if (load)
        begin
            count_r <= value;
            done_r <= (value == '0);
        end
        else if (count_r != '0)
        begin
            count_r <= count_r - 1'b1;
            done_r <= (count_r == {{(W-1){1'b0}}, 1'b1});
        end
        else
        begin
            done_r <= 1'b1;
        end
    end

    assign done = done_r;
endmodule : wait_timer

// file: diff_clock_gen.sv
// divided differential memory clock with a command launch pulse
`timescale 1ns/1ps
module diff_clock_gen #(
    parameter int DIV = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    output logic clk_true,
    output logic clk_comp,
    output logic launch
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] HALF = CW'(DIV / 2);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic clk_r;
    logic launch_r;

    always_comb
    begin
        cnt_nxt = '0;
        if (run)
            cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end

    // launch pulses in the first cycle of the low half, so a command gets DIV/2 - 1 aclk cycles of setup
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r <= '0;
            clk_r <= 1'b0;
            launch_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            clk_r <= run && (cnt_nxt < HALF);
            launch_r <= run && (cnt_nxt == HALF);
        end
    end

    assign clk_true = clk_r;
    assign clk_comp = ~clk_r;
    assign launch = launch_r;
endmodule : diff_clock_gen

// file: dram_dev_model.sv
// memory device model that records what the sequencer programs
`timescale 1ns/1ps
module dram_dev_model (
    input logic mem_reset_n,
    input logic clock_enable,
    input logic diff_clock_true,
    input logic cs_n,
    input logic act_n,
    input logic ras_n,
    input logic cas_n,
    input logic we_n,
    input logic bank_group_bit,
    input logic bank_addr_bit1,
    input logic bank_addr_bit0,
    input logic [13:0] addr
);
    logic [13:0] mr_cap [8];
    logic [20:0] order_r;
    logic [3:0] zq_r;
    logic [2:0] sel;
    logic mode_load, ready, term_live_r;
    assign sel = {bank_group_bit, bank_addr_bit1, bank_addr_bit0};
    assign mode_load = clock_enable && !cs_n && act_n && !ras_n && !cas_n && !we_n;
    assign ready = zq_r == 4'h8;
    // reset wipes progress only; stored mode values survive it
    always_ff @(posedge diff_clock_true or negedge mem_reset_n)
        if (!mem_reset_n)
        begin
            order_r <= 21'h0;
            zq_r <= 4'h0;
            term_live_r <= 1'b0;
        end
        else
        begin
            if (clock_enable) term_live_r <= 1'b1;
            if (mode_load) order_r <= {order_r[17:0], sel};
            if (!cs_n && act_n && ras_n && cas_n && !we_n && addr[10]) zq_r <= 4'h1;
            else if (zq_r != 4'h0 && zq_r != 4'h8) zq_r <= zq_r + 4'h1;
        end
    always_ff @(posedge diff_clock_true)
        if (mode_load) mr_cap[sel] <= addr;
endmodule : dram_dev_model

// file: dram_init_seq_chk.sv
// assertions on the memory pins of the init sequencer
`timescale 1ns/1ps
module dram_init_seq_chk (
    input logic aclk,
    input logic aresetn,
    input logic mem_reset_n,
    input logic clock_enable,
    input logic cs_n,
    input logic act_n,
    input logic ras_n,
    input logic cas_n,
    input logic we_n,
    input logic bank_group_bit,
    input logic bank_addr_bit1,
    input logic bank_addr_bit0,
    input logic [13:0] addr
);
    logic [2:0] sel;
    logic mode_load, cal_cmd;
    assign sel = {bank_group_bit, bank_addr_bit1, bank_addr_bit0};
    assign mode_load = !cs_n && act_n && !ras_n && !cas_n && !we_n;
    assign cal_cmd = !cs_n && act_n && ras_n && cas_n && !we_n && addr[10];
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_cke_in_reset: assert property (!mem_reset_n |-> !clock_enable)
        else $error("cke high in reset");
    chk_cke_wait: assert property ($rose(mem_reset_n) |-> !clock_enable [*8])
        else $error("cke early");
    chk_des_on_cke: assert property ($rose(clock_enable) |-> cs_n)
        else $error("no deselect");
    chk_load_cke: assert property (mode_load |-> clock_enable && mem_reset_n)
        else $error("mode load without cke");
    chk_mode4_zero: assert property (mode_load && sel == 3'h4 |->
        addr[8:5] == 4'h0 && !addr[13]) else $error("mode 4 default");
    chk_mode35_zero: assert property (mode_load |-> (sel != 3'h3 || addr[4:3] == 2'h0) &&
        (sel != 3'h5 || addr[2:0] == 3'h0)) else $error("mode 3 or 5 default");
    chk_cal_after_mode0: assert property ($fell(cs_n) && mode_load && sel == 3'h0 |->
        ##[8:100] cal_cmd) else $error("no calibration");
    chk_cmd_width: assert property ($fell(cs_n) |-> !cs_n [*8] ##1 cs_n)
        else $error("command width");
    cover property (mode_load && sel == 3'h0);
    cover property (cal_cmd);
    cover property ($rose(clock_enable));
endmodule : dram_init_seq_chk
bind dram_init_seq dram_init_seq_chk chk_inst (.*);

// file: tb_top.sv
// self-checking bench for the dram init sequencer
`timescale 1ns/1ps
`include "dram_init_regs.svh"
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic mem_reset_n, clock_enable, connectivity_test_enable, termination_control_in;
    logic diff_clock_true, diff_clock_comp, cs_n, act_n, ras_n, cas_n, we_n;
    logic bank_group_bit, bank_addr_bit1, bank_addr_bit0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [3:0] wstrb = 4'hf;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, resp;
    logic [13:0] addr, e_mr [7];
    int num_errors = 0, n_compared = 0;
    dram_init_seq #(.RESET_HOLD_CYC(20), .CKE_WAIT_CYC(20), .DLL_LOCK_CLKS(8), .ZQ_INIT_CLKS(8),
        .CMD_GAP_CLKS(4)) dram_init_seq_inst (.*);
    dram_dev_model dram_dev_model_inst (.*);
    initial forever #5 aclk = ~aclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) $display("wrong value at %0t: %h expected %h", $time, s, e);
        if (s !== e) num_errors++;
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (awvalid && !awready || wvalid && !wready);
        while (!bvalid) @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic run(input logic [31:0] ctrl, input logic term);
        wr(`INIT_CTRL_OFS, ctrl);
        repeat (3) @(posedge aclk);
        do rd(`INIT_STATUS_OFS); while (d[`INIT_STAT_DONE_BIT] !== 1'b1);
        chk(dram_dev_model_inst.order_r, 21'hf5888);
        chk(dram_dev_model_inst.ready, 1'b1);
        for (int i = 0; i < 7; i++) chk(dram_dev_model_inst.mr_cap[i], e_mr[i]);
        chk(termination_control_in, term);
        chk(connectivity_test_enable, 1'b0);
        chk(diff_clock_comp, !diff_clock_true);
        chk(dram_dev_model_inst.term_live_r, 1'b1);
        $display("init test with control %h done", ctrl);
    endtask : run
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        conclude();
    end
    initial
    begin
        e_mr = '{14'h0abc, 14'h0, 14'h0123, 14'h0007, 14'h1e1f, 14'h0, 14'h0456};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`INIT_CTRL_OFS);
        chk(d, `INIT_CTRL_RESET);
        rd(8'h30);
        chk(resp, 32'h2);
        chk(d, 32'h0);
        for (int i = 0; i < 7; i++) wr(8'h10 + 8'(4 * i), {18'h0, e_mr[i] | (i == 3 ? 14'h18 :
            i == 4 ? 14'h21e0 : i == 5 ? 14'h7 : 14'h0)});
        wr(8'h2c, 32'h1);
        chk(resp, 32'h2);
        $display("register test done");
        run(32'hf, 1'b1);
        wr(8'h14, 32'h100);
        e_mr[1] = 14'h0100;
        run(32'h5, 1'b0);
        conclude();
    end
endmodule : tb_top
